// *** rtl/amp_ctrl_pkg.sv ***
// package with constants, states and timing counts for the amplifier mode controller
// Summary of operation
// - overvoltage forces outputs high impedance, pulls fault line low, updates fault status
// - when supply returns to range after overvoltage, restart and release fault line
// - power above selected limit makes limiter reduce gain until power is below limit or maximum attenuation is reached
// - limiter changes gain in small fixed steps at fixed attack and release intervals in play, jumping back to default when play ends
// - attack from default to attenuated gain takes about 55 ms
// - release from attenuated back to default gain takes about 1.5 s
// - fault line asserts low whenever overvoltage or undervoltage forces outputs high impedance, not for a shorted load in diagnostics
// - shutdown input low gives full shutdown: outputs off, oscillator and bus stopped
// - switching frequency is 400 kHz or 500 kHz per the frequency setting
// - spread spectrum varies the switching period cycle to cycle around centre
// - play switches outputs; diagnostic and fault states keep oscillator and bus active
// - shorted load seen by diagnostics holds outputs off and reruns the test
// - load diagnostics run on leaving shutdown and after every second overvoltage event
// - undervoltage forces outputs off, asserts fault line, resets bus register contents
package amp_ctrl_pkg;
  localparam int unsigned clk_hz = 50000000;
  localparam int unsigned fsw_low_hz = 400000;
  localparam int unsigned fsw_high_hz = 500000;
  localparam int unsigned per_low = clk_hz / fsw_low_hz;
  localparam int unsigned per_high = clk_hz / fsw_high_hz;
  localparam int unsigned attack_us = 55000;
  localparam int unsigned release_us = 1500000;
  localparam int unsigned diag_us = 260000;
  localparam int unsigned gain_steps = 32;
  localparam int unsigned attack_step_cyc = attack_us / gain_steps * (clk_hz / 1000000);
  localparam int unsigned release_step_cyc = release_us / gain_steps * (clk_hz / 1000000);
  localparam int unsigned diag_cyc = diag_us * (clk_hz / 1000000);
  localparam logic [5:0] gain_default = 6'h00;
  localparam logic [5:0] gain_max_atten = 6'h20;
  localparam logic [3:0] ss_seed = 4'h9;
  typedef enum logic [1:0] {st_shutdown, st_diag, st_fault, st_play} amp_state_t;
endpackage

// *** rtl/gain_stepper.sv ***
// stepped gain limiter with separate attack and release intervals
`timescale 1ns/1ns
module gain_stepper #(
  parameter int unsigned attack_cyc = amp_ctrl_pkg::attack_step_cyc,
  parameter int unsigned release_cyc = amp_ctrl_pkg::release_step_cyc
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic over_limit,
  // gain out
  output logic [5:0] atten
);
  logic [26:0] tick;
  logic [26:0] next_tick;
  logic [5:0] next_atten;
  always_comb begin
    next_tick = tick + 27'h1;
    next_atten = atten;
    if (!run) begin
      next_tick = 27'h0;
      next_atten = amp_ctrl_pkg::gain_default;
    end else if (over_limit) begin
      if (tick >= 27'(attack_cyc - 1)) begin
        next_tick = 27'h0;
        if (atten < amp_ctrl_pkg::gain_max_atten) next_atten = atten + 6'h1;
      end
    end else if (tick >= 27'(release_cyc - 1)) begin
      next_tick = 27'h0;
      if (atten != amp_ctrl_pkg::gain_default) next_atten = atten - 6'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tick <= 27'h0;
      atten <= amp_ctrl_pkg::gain_default;
    end else begin
      tick <= next_tick;
      atten <= next_atten;
    end
  end
endmodule // gain_stepper

// *** rtl/amp_fault_mode_controller.sv ***
// mode, protection, limiter and switching clock control for the amplifier
`timescale 1ns/1ns
module amp_fault_mode_controller #(
  parameter int unsigned attack_cyc = amp_ctrl_pkg::attack_step_cyc,
  parameter int unsigned release_cyc = amp_ctrl_pkg::release_step_cyc,
  parameter int unsigned diag_cyc = amp_ctrl_pkg::diag_cyc
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // pins from outside
  input wire logic shutdown_request_n,
  input wire logic supply_overvoltage,
  input wire logic supply_undervoltage,
  input wire logic load_short,
  input wire logic power_over_limit,
  // settings from the control registers
  input wire logic freq_sel_high,
  input wire logic spread_en,
  input wire logic diag_en,
  // fault line, open drain
  output logic fault_alert_n_out,
  output logic fault_alert_n_oe,
  // output stage and status
  output logic outputs_hiz,
  output logic outputs_switch,
  output logic diag_bias,
  output logic osc_run,
  output logic bus_active,
  output logic regs_reset,
  output logic pwm_tick,
  output logic [5:0] gain_atten,
  output logic [2:0] fault_status,
  output logic [1:0] state_code
);
  logic [1:0] sd_s;
  logic [1:0] ov_s;
  logic [1:0] uv_s;
  logic [1:0] sh_s;
  logic [1:0] pl_s;
  logic sd_n;
  logic ov;
  logic uv;
  logic shrt;
  logic over;
  assign sd_n = sd_s[1];
  assign ov = ov_s[1];
  assign uv = uv_s[1];
  assign shrt = sh_s[1];
  assign over = pl_s[1];

  amp_ctrl_pkg::amp_state_t state;
  amp_ctrl_pkg::amp_state_t next_state;
  logic ov_prev;
  logic next_ov_prev;
  logic ov_parity;
  logic next_ov_parity;
  logic need_diag;
  logic next_need_diag;
  logic [24:0] dcnt;
  logic [24:0] next_dcnt;
  logic [2:0] next_fault_status;
  logic fault_now;

  assign fault_now = ov | uv;

  always_comb begin
    next_state = state;
    next_ov_prev = ov;
    next_ov_parity = ov_parity;
    next_need_diag = need_diag;
    next_dcnt = 25'h0;
    next_fault_status = fault_status;
    if (ov && !ov_prev) begin
      next_ov_parity = ~ov_parity;
      if (ov_parity) next_need_diag = 1'b1;
    end
    if (ov) next_fault_status[0] = 1'b1;
    if (uv) next_fault_status[1] = 1'b1;
    if (!sd_n) begin
      next_state = amp_ctrl_pkg::st_shutdown;
    end else begin
      unique case (state)
        amp_ctrl_pkg::st_shutdown: begin
          next_state = diag_en ? amp_ctrl_pkg::st_diag : amp_ctrl_pkg::st_play;
        end
        amp_ctrl_pkg::st_diag: begin
          next_dcnt = dcnt + 25'h1;
          if (fault_now) begin
            next_state = amp_ctrl_pkg::st_fault;
          end else if (dcnt >= 25'(diag_cyc - 1)) begin
            next_dcnt = 25'h0;
            if (shrt) begin
              next_fault_status[2] = 1'b1;
            end else begin
              next_state = amp_ctrl_pkg::st_play;
              next_need_diag = 1'b0;
            end
          end
        end
        amp_ctrl_pkg::st_fault: begin
          if (!fault_now) begin
            next_state = (need_diag && diag_en) ? amp_ctrl_pkg::st_diag : amp_ctrl_pkg::st_play;
            next_need_diag = 1'b0;
          end
        end
        amp_ctrl_pkg::st_play: begin
          if (fault_now) next_state = amp_ctrl_pkg::st_fault;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sd_s <= 2'h0;
      ov_s <= 2'h0;
      uv_s <= 2'h0;
      sh_s <= 2'h0;
      pl_s <= 2'h0;
      state <= amp_ctrl_pkg::st_shutdown;
      ov_prev <= 1'b0;
      ov_parity <= 1'b0;
      need_diag <= 1'b0;
      dcnt <= 25'h0;
      fault_status <= 3'h0;
    end else begin
      sd_s <= {sd_s[0], shutdown_request_n};
      ov_s <= {ov_s[0], supply_overvoltage};
      uv_s <= {uv_s[0], supply_undervoltage};
      sh_s <= {sh_s[0], load_short};
      pl_s <= {pl_s[0], power_over_limit};
      state <= next_state;
      ov_prev <= next_ov_prev;
      ov_parity <= next_ov_parity;
      need_diag <= next_need_diag;
      dcnt <= next_dcnt;
      fault_status <= (uv || !sd_n) ? {1'b0, uv, 1'b0} : next_fault_status;
    end
  end

  // mode outputs
  assign outputs_hiz = (state != amp_ctrl_pkg::st_play);
  assign outputs_switch = (state == amp_ctrl_pkg::st_play);
  assign diag_bias = (state == amp_ctrl_pkg::st_diag);
  assign osc_run = (state != amp_ctrl_pkg::st_shutdown);
  assign bus_active = (state != amp_ctrl_pkg::st_shutdown);
  assign regs_reset = uv;
  assign fault_alert_n_out = 1'b0;
  assign fault_alert_n_oe = (state == amp_ctrl_pkg::st_fault) && fault_now;
  assign state_code = state[1:0];

  // gain limiter
  gain_stepper #(
    .attack_cyc(attack_cyc),
    .release_cyc(release_cyc)
  ) u_gain (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(outputs_switch),
    .over_limit(over),
    .atten(gain_atten)
  );

  // switching clock with optional spread
  logic [7:0] pcnt;
  logic [7:0] next_pcnt;
  logic [3:0] lfsr;
  logic [3:0] next_lfsr;
  logic [7:0] period;
  logic next_pwm_tick;
  always_comb begin
    period = freq_sel_high ? 8'(amp_ctrl_pkg::per_high) : 8'(amp_ctrl_pkg::per_low);
    if (spread_en) period = period - 8'h8 + {4'h0, lfsr};
    next_pcnt = pcnt + 8'h1;
    next_lfsr = lfsr;
    next_pwm_tick = 1'b0;
    if (!osc_run) begin
      next_pcnt = 8'h0;
    end else if (pcnt >= period - 8'h1) begin
      next_pcnt = 8'h0;
      next_pwm_tick = 1'b1;
      next_lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pcnt <= 8'h0;
      lfsr <= amp_ctrl_pkg::ss_seed;
      pwm_tick <= 1'b0;
    end else begin
      pcnt <= next_pcnt;
      lfsr <= next_lfsr;
      pwm_tick <= next_pwm_tick;
    end
  end
endmodule // amp_fault_mode_controller

// *** tb/host_model.sv ***
// host side model: fault line pull-up and shutdown pin
`timescale 1ns/1ns
module host_model (
  // host command
  input wire logic sd_cmd,
  // open-drain fault line from the device
  input wire logic alert_out,
  input wire logic alert_oe,
  // pins seen by both sides
  output logic shutdown_request_n,
  output logic fault_line
);
  assign fault_line = alert_oe ? alert_out : 1'b1;
  assign shutdown_request_n = sd_cmd;
endmodule // host_model

// *** tb/amp_ctrl_checker.sv ***
// assertion checker for the amplifier mode controller
`timescale 1ns/1ns
module amp_ctrl_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // watched pins
  input wire logic shutdown_request_n,
  input wire logic supply_overvoltage,
  input wire logic supply_undervoltage,
  input wire logic fault_alert_n_out,
  input wire logic fault_alert_n_oe,
  input wire logic outputs_hiz,
  input wire logic outputs_switch,
  input wire logic osc_run,
  input wire logic bus_active,
  input wire logic regs_reset,
  input wire logic [5:0] gain_atten,
  input wire logic [2:0] fault_status,
  input wire logic [1:0] state_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_sd_off: assert property (state_code == 2'h0 |-> outputs_hiz && !osc_run && !bus_active)
    else $error("shutdown outputs wrong");
  chk_play_run: assert property (state_code == 2'h3 |-> outputs_switch && !outputs_hiz && osc_run && bus_active)
    else $error("play outputs wrong");
  chk_fault_hiz: assert property (state_code == 2'h2 |-> outputs_hiz && !outputs_switch && osc_run)
    else $error("fault outputs wrong");
  chk_alert_hiz: assert property (fault_alert_n_oe |-> outputs_hiz && !fault_alert_n_out)
    else $error("alert without hiz");
  chk_ov_trip: assert property (state_code == 2'h3 && supply_overvoltage && shutdown_request_n
    |-> ##[1:4] (state_code == 2'h2 && fault_alert_n_oe && fault_status[0]))
    else $error("overvoltage not trapped");
  chk_gain_step: assert property (state_code == 2'h3 && $past(state_code) == 2'h3
    |-> gain_atten == $past(gain_atten) || gain_atten == $past(gain_atten) + 6'h01
    || gain_atten == $past(gain_atten) - 6'h01)
    else $error("gain jumped");
  chk_gain_cap: assert property (gain_atten <= amp_ctrl_pkg::gain_max_atten)
    else $error("gain beyond range");
  chk_sd_wins: assert property (!shutdown_request_n [*4] |-> state_code == 2'h0)
    else $error("shutdown not taken");
  chk_uv_regs: assert property (supply_undervoltage [*4] |-> regs_reset)
    else $error("regs not reset");
  cover property (state_code == 2'h1 && fault_status[2]);
  cover property ($rose(fault_alert_n_oe));
  cover property (gain_atten == 6'h20);
endmodule // amp_ctrl_checker
bind amp_fault_mode_controller amp_ctrl_checker u_amp_ctrl_checker (.sys_clk(sys_clk),
  .rstn(rstn), .shutdown_request_n(shutdown_request_n), .supply_overvoltage(supply_overvoltage),
  .supply_undervoltage(supply_undervoltage), .fault_alert_n_out(fault_alert_n_out),
  .fault_alert_n_oe(fault_alert_n_oe), .outputs_hiz(outputs_hiz),
  .outputs_switch(outputs_switch), .osc_run(osc_run), .bus_active(bus_active),
  .regs_reset(regs_reset), .gain_atten(gain_atten), .fault_status(fault_status),
  .state_code(state_code));

// *** tb/amp_fault_mode_controller_test.sv ***
// self-checking bench for the amplifier mode controller
`timescale 1ns/1ns
module amp_fault_mode_controller_test;
  logic sys_clk = 0, rstn = 0, sd_cmd = 0, ov = 0, uv = 0, shrt = 0, pol = 0;
  logic fsel = 0, spr = 0, den = 0, hiz, sw, bias, osc, bus, rr, tick, oe, fo, fline, sdn;
  logic [5:0] gain;
  logic [2:0] fst;
  logic [1:0] st;
  int fails = 0, check_count = 0, p, n, d;
  always #10 sys_clk = ~sys_clk;
  host_model u_host_model (.sd_cmd(sd_cmd), .alert_out(fo), .alert_oe(oe),
    .shutdown_request_n(sdn), .fault_line(fline));
  amp_fault_mode_controller #(.attack_cyc(4), .release_cyc(8), .diag_cyc(20))
    u_amp_fault_mode_controller (.sys_clk(sys_clk), .rstn(rstn), .shutdown_request_n(sdn),
    .supply_overvoltage(ov), .supply_undervoltage(uv), .load_short(shrt),
    .power_over_limit(pol), .freq_sel_high(fsel), .spread_en(spr), .diag_en(den),
    .fault_alert_n_out(fo), .fault_alert_n_oe(oe), .outputs_hiz(hiz), .outputs_switch(sw),
    .diag_bias(bias), .osc_run(osc), .bus_active(bus), .regs_reset(rr), .pwm_tick(tick),
    .gain_atten(gain), .fault_status(fst), .state_code(st));
  task automatic chk(input logic c);
    check_count++;
    if (c !== 1'b1) begin
      fails++;
      $display("ERROR %0t: mismatch", $time);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 400 && st !== s; i++) cyc(1);
    chk(st === s);
  endtask
  task automatic period(output int q);
    for (int i = 0; i < 300 && tick !== 1'b1; i++) cyc(1);
    q = 0;
    do begin cyc(1); q++; end while (tick !== 1'b1 && q < 300);
  endtask
  task automatic ramp(input logic [5:0] tgt, output int k);
    logic [5:0] g;
    g = gain;
    for (k = 0; k < 2000 && gain !== tgt; k++) begin
      cyc(1);
      chk(gain === g || gain === g + 6'h01 || gain === g - 6'h01);
      g = gain;
    end
  endtask
  task automatic ov_event(input logic [1:0] nxt);
    @(posedge sys_clk) ov <= 1'b1;
    wait_st(2'h2);
    chk(hiz === 1'b1 && fline === 1'b0 && fst[0] === 1'b1);
    @(posedge sys_clk) ov <= 1'b0;
    wait_st(nxt);
    chk(fline === 1'b1);
  endtask
  task automatic close_out;
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    chk(st === 2'h0 && hiz === 1'b1 && osc === 1'b0 && oe === 1'b0);
    @(posedge sys_clk) rstn <= 1'b1;
    cyc(10);
    chk(st === 2'h0 && osc === 1'b0 && bus === 1'b0 && fline === 1'b1);
    @(posedge sys_clk) sd_cmd <= 1'b1;
    wait_st(2'h3);
    chk(sw === 1'b1 && hiz === 1'b0 && osc === 1'b1 && bus === 1'b1);
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk) fsel <= f[0];
      cyc(300);
      period(p);
      chk(p == (f ? amp_ctrl_pkg::per_high : amp_ctrl_pkg::per_low));
    end
    @(posedge sys_clk) spr <= 1'b1;
    cyc(300);
    d = 0;
    repeat (6) begin
      period(p);
      chk(p >= amp_ctrl_pkg::per_high - 8 && p <= amp_ctrl_pkg::per_high + 7);
      if (p != amp_ctrl_pkg::per_high) d++;
    end
    chk(d > 0);
    @(posedge sys_clk) pol <= 1'b1;
    ramp(6'h20, n);
    chk(gain === 6'h20 && n >= 31 * 4);
    @(posedge sys_clk) pol <= 1'b0;
    ramp(6'h00, n);
    chk(gain === 6'h00 && n >= 31 * 8);
    @(posedge sys_clk) den <= 1'b1;
    ov_event(2'h3);
    ov_event(2'h1);
    @(posedge sys_clk) shrt <= 1'b1;
    cyc(100);
    chk(st === 2'h1 && sw === 1'b0 && bias === 1'b1 && fst[2] === 1'b1);
    @(posedge sys_clk) shrt <= 1'b0;
    wait_st(2'h3);
    @(posedge sys_clk) uv <= 1'b1;
    wait_st(2'h2);
    chk(rr === 1'b1 && fline === 1'b0 && hiz === 1'b1 && fst[1] === 1'b1);
    @(posedge sys_clk) sd_cmd <= 1'b0;
    wait_st(2'h0);
    @(posedge sys_clk) uv <= 1'b0;
    @(posedge sys_clk) ov <= 1'b1;
    cyc(20);
    chk(st === 2'h0 && hiz === 1'b1 && osc === 1'b0);
    close_out();
  end
  initial begin
    cyc(20000);
    fails++;
    close_out();
  end
endmodule // amp_fault_mode_controller_test
